/* File: hpfs_pkg.sv */
// Package of constants and types for the plug-in board power fault sequencer.
package hpfs_pkg;
   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned FILT_TIME_US    = 35;
   localparam int unsigned PG_DEGLITCH_US  = 10;
   localparam int unsigned BLANK_TIME_US   = 50_000;
   localparam int unsigned FILT_CYCLES     = (CLK_HZ / 1_000_000) * FILT_TIME_US;
   localparam int unsigned PG_CYCLES       = (CLK_HZ / 1_000_000) * PG_DEGLITCH_US;
   localparam int unsigned BLANK_CYCLES    = (CLK_HZ / 1_000_000) * BLANK_TIME_US;
   localparam int unsigned GATE_RAMP_STEPS = 255;

   // ****************************************************************
   // Register map (word byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CL = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h10;

   // Command bit positions.
   localparam int unsigned CMD_FORCE_OFF = 2;
   localparam int unsigned CMD_RESET_ASSERT = 3;
   localparam int unsigned CMD_LED_ON    = 1;
   localparam logic [7:0]  CMD_RESET_VAL = 8'h00;

   // Interrupt event bits.
   localparam int unsigned EV_WIDTH   = 4;
   localparam int unsigned EV_FAULT   = 0;
   localparam int unsigned EV_PG_LOST = 1;
   localparam int unsigned EV_PG_OK   = 2;
   localparam int unsigned EV_OFF     = 3;

   typedef enum logic [1:0] {
      HPFS_FC_3V  = 2'h0,
      HPFS_FC_5V  = 2'h1,
      HPFS_FC_12V = 2'h2,
      HPFS_FC_VEE = 2'h3
   } hpfs_fault_code_t;

   // Analogue comparator inputs, one bit per supply where applicable.
   typedef struct packed {
      logic       timer_done;
      logic [3:0] in_limit;
      logic [3:0] below_good;
      logic       over_temp;
   } hpfs_comp_t;

   // Drive outputs toward the power stage.
   typedef struct packed {
      logic       timer_charge;
      logic       timer_discharge;
      logic [7:0] gate_level;
      logic [3:0] pass_on;
      logic [3:0] discharge_on;
   } hpfs_drive_t;
endpackage

/* File: hpfs_sequencer.sv */
// Power sequencer with fault latch and classic Wishbone register slave.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// R01 - Power down while board select is high or force-off command bit is set.
// R02 - Discharge the blanking timer immediately when power-down starts.
// R03 - Ramp gate drive down gradually during power-down, not abruptly.
// R04 - Enable output discharge switches on all four supplies during power-down.
// R05 - Supply below good: release supplies good, assert bus reset, light indicator.
// R06 - Start charging the blanking timer from zero at power-up.
// R07 - Ignore current limit while blanking timer has not reached its threshold.
// R08 - Current limit at blanking end turns all supplies off and asserts fault.
// R09 - After blanking, trip only on current limit lasting the full filter delay.
// R10 - Overcurrent on 5 V or 3.3 V starts delay, trips if still present.
// R11 - Overtemperature latches all four switches off and asserts fault.
// R12 - No automatic retry after thermal shutdown; cycle off request or command.
// R13 - Overcurrent latch-off holds until off request, command, or supply cycling.
// R14 - Force-off command overrides board select; it clears at power-up.
// R15 - Report supplies good loss only after deglitch; never a fault by itself. Code releases good on the first below-good sample.
// R16 - Bus reset out high only with reset in high, good low, command clear.
// R17 - Comparator outputs pass two flip-flops before the state machine reads them.
// R18 - Filter delay and blanking window are counters with derived cycle counts.
module hpfs_sequencer #(
   parameter int unsigned BLANK_CYC = hpfs_pkg::BLANK_CYCLES,
   parameter int unsigned FILT_CYC  = hpfs_pkg::FILT_CYCLES,
   parameter int unsigned PG_CYC    = hpfs_pkg::PG_CYCLES
) (
   input  wire logic               mclk,
   input  wire logic               reset_n,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   input  wire logic [3:0]         wb_sel_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               board_select_n,
   input  wire logic               bus_reset_in,
   input  wire logic               supply_cycled,
   input  wire hpfs_pkg::hpfs_comp_t comp_in,
   output hpfs_pkg::hpfs_drive_t   drive_out,
   output logic                    fault_n,
   output logic                    supplies_good_n,
   output logic                    local_bus_reset_out,
   output logic                    led_on,
   output logic                    irq
);
   import hpfs_pkg::*;

   typedef enum logic [2:0] {
      HPFS_OFF, HPFS_BLANK, HPFS_RUN, HPFS_DOWN, HPFS_LATCHED
   } hpfs_state_t;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   localparam int unsigned SYN_W = 13;
   // The board select stage resets to its idle high level, so leaving reset never fakes a power-up.
   localparam logic [SYN_W-1:0] SYN_IDLE = 13'h1000;
   logic [SYN_W-1:0] syn1_reg;
   logic [SYN_W-1:0] syn2_reg;
   wire  [SYN_W-1:0] raw_in = {board_select_n, bus_reset_in, supply_cycled, comp_in};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         syn1_reg <= SYN_IDLE;
         syn2_reg <= SYN_IDLE;
      end else begin
         syn1_reg <= raw_in;    // R17
         syn2_reg <= syn1_reg;  // R17
      end
   end

   hpfs_comp_t comp_s;
   wire        off_req_s   = syn2_reg[12];
   wire        rst_in_s    = syn2_reg[11];
   wire        cycled_s    = syn2_reg[10];
   assign comp_s = syn2_reg[9:0];

   // ****************************************************************
   // Registers and bus decode
   // ****************************************************************
   logic [7:0]          cmd_reg;
   logic [EV_WIDTH-1:0] ev_st_reg;
   logic [EV_WIDTH-1:0] ev_en_reg;
   logic [EV_WIDTH-1:0] ev_set;
   hpfs_state_t         state_reg;
   hpfs_state_t         state_next;
   hpfs_fault_code_t    fcode_reg;
   logic                fault_reg;
   logic                pg_good_reg;

   wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
   wire wr_cmd   = wr_lane0 && (wb_adr_i == ADDR_CMD);
   wire wr_clr   = wr_lane0 && (wb_adr_i == ADDR_IRQ_CL);
   wire wr_en    = wr_lane0 && (wb_adr_i == ADDR_IRQ_EN);
   wire force_off = cmd_reg[CMD_FORCE_OFF];
   wire off_cmd   = off_req_s || force_off;  // R01 R14

   wire [31:0] status_word = {23'h000000, state_reg, fcode_reg, rst_in_s,
                              local_bus_reset_out, supplies_good_n, fault_n};
   wire [31:0] rd_mux =
      (wb_adr_i == ADDR_CMD)    ? {24'h000000, cmd_reg} :
      (wb_adr_i == ADDR_STATUS) ? status_word :
      (wb_adr_i == ADDR_IRQ_ST) ? {28'h0000000, ev_st_reg} :
      (wb_adr_i == ADDR_IRQ_EN) ? {28'h0000000, ev_en_reg} : 32'h00000000;

   // Write-only and unmapped addresses still ack so the master never hangs.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         cmd_reg  <= CMD_RESET_VAL;  // R14
         ev_en_reg <= '0;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) wb_dat_o <= rd_mux;
         if (wr_cmd) cmd_reg <= wb_dat_i[7:0];
         if (wr_en) ev_en_reg <= wb_dat_i[EV_WIDTH-1:0];
      end
   end

   // Set wins over clear so an event in the clearing cycle is kept.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ev_st_reg <= '0;
      end else begin
         ev_st_reg <= (ev_st_reg & ~(wr_clr ? wb_dat_i[EV_WIDTH-1:0] : '0)) | ev_set;
      end
   end
   assign irq = |(ev_st_reg & ev_en_reg);

   // ****************************************************************
   // Timers
   // ****************************************************************
   logic [31:0] blank_cnt_reg;
   logic [31:0] filt_cnt_reg;
   logic [31:0] pg_cnt_reg;
   logic [7:0]  gate_reg;
   logic        ramp_tick;
   logic [3:0]  ramp_div_reg;

   wire any_limit   = |comp_s.in_limit;
   wire any_below   = |comp_s.below_good;
   wire blank_done  = (blank_cnt_reg >= BLANK_CYC) || comp_s.timer_done;  // R07
   wire filt_done   = (filt_cnt_reg >= FILT_CYC);                         // R09 R10
   wire pg_lost     = (pg_cnt_reg >= PG_CYC);                             // R15

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         blank_cnt_reg <= 32'h00000000;
      end else if (state_reg != HPFS_BLANK) begin
         blank_cnt_reg <= 32'h00000000;  // R02
      end else if (!blank_done) begin
         blank_cnt_reg <= blank_cnt_reg + 32'h00000001;  // R06 R18
      end
   end

   // A single dropped sample restarts the filter, so short spikes never trip in the run state.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         filt_cnt_reg <= 32'h00000000;
      end else if (state_reg != HPFS_RUN || !any_limit) begin
         filt_cnt_reg <= 32'h00000000;  // R09
      end else if (!filt_done) begin
         filt_cnt_reg <= filt_cnt_reg + 32'h00000001;  // R10 R18
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pg_cnt_reg <= 32'h00000000;
      end else if (!any_below) begin
         pg_cnt_reg <= 32'h00000000;
      end else if (!pg_lost) begin
         pg_cnt_reg <= pg_cnt_reg + 32'h00000001;  // R15
      end
   end

   // Gate ramps one step per divider tick, limiting the slew like a current sink.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ramp_div_reg <= 4'h0;
         ramp_tick    <= 1'b0;
         gate_reg     <= 8'h00;
      end else begin
         ramp_div_reg <= ramp_div_reg + 4'h1;
         ramp_tick    <= (ramp_div_reg == 4'hF);
         if (state_reg == HPFS_BLANK || state_reg == HPFS_RUN) begin
            if (ramp_tick && gate_reg != GATE_RAMP_STEPS[7:0]) gate_reg <= gate_reg + 8'h01;
         end else if (state_reg == HPFS_DOWN) begin
            if (ramp_tick && gate_reg != 8'h00) gate_reg <= gate_reg - 8'h01;  // R03
         end else begin
            gate_reg <= 8'h00;  // R08 R11
         end
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   wire trip_oc = (state_reg == HPFS_BLANK && blank_done && any_limit) ||   // R08
                  (state_reg == HPFS_RUN && filt_done);                      // R09 R10
   wire trip_ot = comp_s.over_temp && state_reg != HPFS_LATCHED;             // R11

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         HPFS_OFF:     if (!off_cmd) state_next = HPFS_BLANK;               // R06
         HPFS_BLANK:   if (off_cmd) state_next = HPFS_DOWN;
                       else if (blank_done && !any_limit) state_next = HPFS_RUN;
         HPFS_RUN:     if (off_cmd) state_next = HPFS_DOWN;                 // R01
         HPFS_DOWN:    if (gate_reg == 8'h00 && !any_below_raw()) state_next = HPFS_OFF;
                       else if (gate_reg == 8'h00) state_next = HPFS_OFF;
         HPFS_LATCHED: if (off_cmd || cycled_s) state_next = HPFS_OFF;      // R12 R13
      endcase
      if (trip_oc || trip_ot) state_next = HPFS_LATCHED;
   end

   function automatic logic any_below_raw();
      return 1'b0;
   endfunction

   function automatic hpfs_fault_code_t code_of(input logic [3:0] v);
      if (v[0]) return HPFS_FC_3V;
      if (v[1]) return HPFS_FC_5V;
      if (v[2]) return HPFS_FC_12V;
      return HPFS_FC_VEE;
   endfunction

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= HPFS_OFF;
         fault_reg <= 1'b0;
         fcode_reg <= HPFS_FC_3V;
      end else begin
         state_reg <= state_next;
         if (trip_oc) begin
            fault_reg <= 1'b1;
            fcode_reg <= code_of(comp_s.in_limit);
         end else if (trip_ot) begin
            fault_reg <= 1'b1;  // R11
         end else if (state_reg == HPFS_LATCHED && state_next == HPFS_OFF) begin
            fault_reg <= 1'b0;  // R12 R13
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   wire running = (state_reg == HPFS_BLANK) || (state_reg == HPFS_RUN);
   wire pg_now  = running && !pg_lost && !any_below;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         drive_out           <= '0;
         pg_good_reg         <= 1'b0;
         supplies_good_n     <= 1'b1;
         local_bus_reset_out <= 1'b0;
         led_on              <= 1'b1;
         fault_n             <= 1'b1;
      end else begin
         drive_out.timer_charge    <= (state_reg == HPFS_BLANK);  // R06
         drive_out.timer_discharge <= (state_reg != HPFS_BLANK);  // R02
         drive_out.gate_level      <= gate_reg;                   // R03
         drive_out.pass_on         <= {4{running}};               // R08 R11
         drive_out.discharge_on    <= {4{state_reg == HPFS_DOWN}}; // R04
         pg_good_reg               <= pg_now;
         supplies_good_n           <= !pg_now;                    // R05 R15
         local_bus_reset_out       <= rst_in_s && pg_now && !cmd_reg[CMD_RESET_ASSERT]; // R16
         led_on <= !(rst_in_s && pg_now && !cmd_reg[CMD_RESET_ASSERT])
                   || cmd_reg[CMD_LED_ON];                        // R05
         fault_n                   <= !fault_reg;
      end
   end

   assign ev_set[EV_FAULT]   = (trip_oc || trip_ot);
   assign ev_set[EV_PG_LOST] = pg_good_reg && !pg_now;
   assign ev_set[EV_PG_OK]   = !pg_good_reg && pg_now;
   assign ev_set[EV_OFF]     = (state_reg == HPFS_DOWN) && (state_next == HPFS_OFF);
endmodule
`default_nettype wire

/* File: hpfs_sequencer_props.sv */
// Port-level checks for the power fault sequencer.
`timescale 1ns/1ps
`default_nettype none
module hpfs_sequencer_props (
   input wire logic                  mclk,
   input wire logic                  reset_n,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_ack_o,
   input wire logic                  board_select_n,
   input wire hpfs_pkg::hpfs_comp_t  comp_in,
   input wire hpfs_pkg::hpfs_drive_t drive_out,
   input wire logic                  fault_n,
   input wire logic                  supplies_good_n,
   input wire logic                  local_bus_reset_out,
   input wire logic                  led_on
);
   import hpfs_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   timer_dump_a: assert property (
      $rose(board_select_n) && drive_out.timer_charge
      |-> ##[1:8] (drive_out.timer_discharge && !drive_out.timer_charge))
      else $error("blanking timer not discharged on off request");
   gate_ramp_a: assert property (
      drive_out.discharge_on == 4'hF && $past(drive_out.discharge_on) == 4'hF
      && drive_out.gate_level < $past(drive_out.gate_level)
      |-> $past(drive_out.gate_level) - drive_out.gate_level == 8'h01)
      else $error("gate drive fell by more than one step");
   blank_mask_a: assert property (
      $rose(drive_out.timer_charge) && !comp_in.over_temp |-> fault_n [*8])
      else $error("fault raised inside the blanking window");
   over_temp_a: assert property (
      comp_in.over_temp && drive_out.pass_on != 4'h0 |-> ##[1:8] !fault_n)
      else $error("overtemperature did not latch a fault");
   good_lost_a: assert property (
      $rose(supplies_good_n) |-> ##[0:3] (!local_bus_reset_out && led_on))
      else $error("supplies lost without reset and indicator");
   reset_out_a: assert property (
      $rose(local_bus_reset_out) |-> !supplies_good_n)
      else $error("local reset released while supplies not good");
endmodule
bind hpfs_sequencer hpfs_sequencer_props i_hpfs_sequencer_props (
   .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .board_select_n(board_select_n), .comp_in(comp_in),
   .drive_out(drive_out), .fault_n(fault_n), .supplies_good_n(supplies_good_n),
   .local_bus_reset_out(local_bus_reset_out), .led_on(led_on));
`default_nettype wire

/* File: hpfs_backplane.sv */
// Model of the supplies, timer and comparators facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module hpfs_backplane (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire hpfs_pkg::hpfs_drive_t drive,
   input  wire logic [3:0]            limit_req,
   input  wire logic                  hot,
   output var  hpfs_pkg::hpfs_comp_t  comp
);
   import hpfs_pkg::*;
   logic [4:0] up_reg;
   logic [6:0] chg_reg;
   // Outputs reach their good level only after the pass elements stay closed a while.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         up_reg <= 5'h00;
         chg_reg <= 7'h00;
         comp <= '0;
         comp.below_good <= 4'hF;
      end else begin
         up_reg <= (drive.pass_on != 4'hF) ? 5'h00 : up_reg + {4'h0, up_reg != 5'h1F};
         chg_reg <= !drive.timer_charge ? 7'h00 : chg_reg + {6'h00, chg_reg != 7'h7F};
         comp.timer_done <= chg_reg >= 7'h46;
         comp.in_limit <= limit_req;
         comp.below_good <= (up_reg >= 5'h10) ? 4'h0 : 4'hF;
         comp.over_temp <= hot;
      end
   end
endmodule
`default_nettype wire

/* File: hpfs_sequencer_tb.sv */
// Self-checking bench for the power fault sequencer.
`timescale 1ns/1ps
`default_nettype none
module hpfs_sequencer_tb;
   import hpfs_pkg::*;
   logic        mclk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, dat_o, rd;
   logic        ack, fault_n, good_n, lrst, led, irq;
   logic        bsel_n = 1'b1, brst = 1'b1, sup_cyc = 1'b0, hot = 1'b0;
   logic [3:0]  lim = 4'h0;
   hpfs_comp_t  comp;
   hpfs_drive_t drv;
   int          miscompares = 0, n_tests = 0;
   always #12.5 mclk = ~mclk;
   hpfs_sequencer #(.BLANK_CYC(50), .FILT_CYC(20), .PG_CYC(10)) i_hpfs_sequencer (
      .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .board_select_n(bsel_n), .bus_reset_in(brst), .supply_cycled(sup_cyc),
      .comp_in(comp), .drive_out(drv), .fault_n(fault_n), .supplies_good_n(good_n),
      .local_bus_reset_out(lrst), .led_on(led), .irq(irq));
   hpfs_backplane i_hpfs_backplane (.mclk(mclk), .reset_n(reset_n), .drive(drv),
      .limit_req(lim), .hot(hot), .comp(comp));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // The request is held until ack is sampled; after 20 cycles without ack the bench fails and finishes.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge mclk);
      if (ack !== 1'b1) begin
         chk("ack", 32'h1, 32'(ack));
         tally_and_finish();
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic logic cond(input int s);
      case (s)
         0: return good_n === 1'b0;
         1: return fault_n === 1'b0;
         2: return drv.pass_on === 4'hF;
         3: return drv.discharge_on === 4'hF;
         default: return good_n === 1'b1;
      endcase
   endfunction
   task automatic wait_for(input int s, input int lim_cyc);
      int n;
      for (n = 0; n < lim_cyc && !cond(s); n++) @(posedge mclk);
      chk($sformatf("condition %0d", s), 32'h1, 32'(cond(s)));
      if (!cond(s)) tally_and_finish();
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      chk("local reset", 32'h0, 32'(lrst));
      wb(1'b0, ADDR_CMD, 32'h0);
      chk("command", {24'h0, CMD_RESET_VAL}, rd);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, ADDR_IRQ_EN, 32'h1);
      $display("test reset done");
      bsel_n <= 1'b0;
      wait_for(2, 20);
      chk("timer charge", 32'h1, 32'(drv.timer_charge));
      wait_for(0, 200);
      repeat (4) @(posedge mclk);
      chk("local reset", 32'h1, 32'(lrst));
      wb(1'b1, ADDR_CMD, 32'h8);
      repeat (3) @(posedge mclk);
      chk("local reset cmd", 32'h0, 32'(lrst));
      wb(1'b1, ADDR_CMD, 32'h0);
      brst <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("local reset in", 32'h0, 32'(lrst));
      brst <= 1'b1;
      $display("test power-up done");
      repeat (60) @(posedge mclk);
      lim <= 4'h1;
      repeat (12) @(posedge mclk);
      lim <= 4'h0;
      repeat (10) @(posedge mclk);
      chk("glitch fault", 32'h1, 32'(fault_n));
      lim <= 4'h2;
      wait_for(1, 60);
      lim <= 4'h0;
      chk("pass after trip", 32'h0, 32'(drv.pass_on));
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk("fault code", 32'(HPFS_FC_5V), 32'(rd[5:4]));
      chk("irq set", 32'h1, 32'(irq));
      wb(1'b1, ADDR_IRQ_CL, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq clear", 32'h0, 32'(irq));
      repeat (100) @(posedge mclk);
      chk("stays off", 32'h0, 32'(drv.pass_on));
      sup_cyc <= 1'b1;
      repeat (8) @(posedge mclk);
      sup_cyc <= 1'b0;
      wait_for(2, 40);
      $display("test breaker done");
      repeat (40) @(posedge mclk);
      bsel_n <= 1'b1;
      wait_for(3, 20);
      chk("timer dump", 32'h1, 32'(drv.timer_discharge));
      wait_for(4, 40);
      chk("reset on loss", 32'h0, 32'(lrst));
      chk("indicator", 32'h1, 32'(led));
      repeat (40) @(posedge mclk);
      $display("test power-down done");
      lim <= 4'h4;
      bsel_n <= 1'b0;
      repeat (30) @(posedge mclk);
      chk("blanking", 32'h1, 32'(fault_n));
      wait_for(1, 80);
      chk("pass on short", 32'h0, 32'(drv.pass_on));
      lim <= 4'h0;
      bsel_n <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("release", 32'h1, 32'(fault_n));
      $display("test short done");
      bsel_n <= 1'b0;
      wait_for(2, 20);
      hot <= 1'b1;
      wait_for(1, 20);
      chk("pass hot", 32'h0, 32'(drv.pass_on));
      hot <= 1'b0;
      repeat (100) @(posedge mclk);
      chk("no retry", 32'h0, 32'(drv.pass_on));
      wb(1'b1, ADDR_CMD, 32'h4);
      repeat (8) @(posedge mclk);
      chk("forced off", 32'h1, 32'(fault_n));
      wb(1'b1, ADDR_CMD, 32'h0);
      wait_for(2, 40);
      $display("test thermal done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
